// File: rtl/pmdb2_pkg.sv
/*
  Package for the module disable control register, bank two.
  Holds the register offset, bit positions, reset value and carrier types.
*/
`default_nettype none
package pmdb2_pkg;
  localparam int PMDB2_AW = 4;
  localparam logic [3:0] PMDB2_OFF_CTRL = 4'h0;
  localparam logic [7:0] PMDB2_RESET = 8'h00;
  localparam int PMDB2_BIT_ZCD = 0;
  localparam int PMDB2_BIT_COMPARATOR_ONE = 1;
  localparam int PMDB2_BIT_COMPARATOR_TWO = 2;
  localparam int PMDB2_BIT_ADC = 5;
  localparam int PMDB2_BIT_DAC = 6;
  localparam logic [7:0] PMDB2_IMPL_MASK = 8'h67;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmdb2_req_t;

  typedef struct packed {
    logic dac_off;
    logic adc_compute_off;
    logic comparator_two_off;
    logic comparator_one_off;
    logic zero_cross_off;
  } pmdb2_off_t;
endpackage
`default_nettype wire

// File: rtl/pmdb2_rst_sync.sv
/*
  Reset release synchroniser.
  Assumes an asynchronous active-low reset input and a free-running clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pmdb2_rst_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic rstn_sync
);
  logic meta_r;
  logic hold_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      hold_r <= meta_r;
    end
  end

  assign rstn_sync = hold_r;
endmodule
`default_nettype wire

// File: rtl/pmdb2_top.sv
/*
  Module disable control register, bank two, with its register port.
  Each implemented bit holds one analog-side module off while it is set; the zero-cross bit does so only when the configuration hands it to software.
  The read port answers one cycle after the strobe and never stalls.
  Assumes a register master that never waits and whose strobes last one cycle,
  and a static non-volatile configuration level for the zero-cross detector.
*/
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - A one in bit 6 turns the DAC off, a zero leaves it on.
// - A one in bit 5 turns the ADC with computation off, a zero leaves it on.
// - A one in bit 2 turns comparator two off, a zero leaves it on.
// - A one in bit 1 turns comparator one off, a zero leaves it on.
// - A one in bit 0 turns the zero-cross detector off, a zero leaves it on.
// - The zero-cross disable bit acts only as the non-volatile setting allows.
module pmdb2_top
  import pmdb2_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [PMDB2_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic zero_cross_config_sw_ctrl,
  input wire logic zero_cross_config_forced_off,
  output var pmdb2_off_t module_off
);

  // Decodes the control register address; the write and read paths share it.
  function automatic logic f_ctrl_hit(input pmdb2_req_t request);
    return request.addr == PMDB2_OFF_CTRL;
  endfunction

  // Clears the unimplemented positions so they can never be stored or read back.
  function automatic logic [7:0] f_implemented(input logic [7:0] value);
    return value & PMDB2_IMPL_MASK;
  endfunction

  // Splits a register byte into the five disable fields.
  function automatic pmdb2_off_t f_fields(input logic [7:0] value);
    pmdb2_off_t fields;
    fields.dac_off = value[PMDB2_BIT_DAC];
    fields.adc_compute_off = value[PMDB2_BIT_ADC];
    fields.comparator_two_off = value[PMDB2_BIT_COMPARATOR_TWO];
    fields.comparator_one_off = value[PMDB2_BIT_COMPARATOR_ONE];
    fields.zero_cross_off = value[PMDB2_BIT_ZCD];
    return fields;
  endfunction

  // Places the five disable fields back at their register positions.
  function automatic logic [7:0] f_image(input pmdb2_off_t fields);
    logic [7:0] value;
    value = '0;
    value[PMDB2_BIT_DAC] = fields.dac_off;
    value[PMDB2_BIT_ADC] = fields.adc_compute_off;
    value[PMDB2_BIT_COMPARATOR_TWO] = fields.comparator_two_off;
    value[PMDB2_BIT_COMPARATOR_ONE] = fields.comparator_one_off;
    value[PMDB2_BIT_ZCD] = fields.zero_cross_off;
    return f_implemented(value);
  endfunction

  // Released copy of the reset; every register below uses it.
  logic rst_n;

  // Register port, bundled and decoded.
  pmdb2_req_t req;
  logic wr_ctrl;
  logic rd_ctrl;
  pmdb2_off_t wr_fields;

  // Stored disable bits and their next values.
  logic dac_off_r;
  logic adc_compute_off_r;
  logic comparator_two_off_r;
  logic comparator_one_off_r;
  logic zero_cross_sw_r;
  logic dac_off_nxt;
  logic adc_compute_off_nxt;
  logic comparator_two_off_nxt;
  logic comparator_one_off_nxt;
  logic zero_cross_sw_nxt;

  // Read path and the qualified zero-cross level.
  pmdb2_off_t stored_bits;
  logic [7:0] image;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic zero_cross_eff;

  // The reset is released in step with the clock so no bit sees a ragged release.
  pmdb2_rst_sync u_rst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .rstn_sync(rst_n)
  );

  // Bundles the register port so one request is decoded.
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Strobes qualified by the address; a miss is dropped without any effect.
  assign wr_ctrl = req.wr && f_ctrl_hit(req);
  assign rd_ctrl = req.rd && f_ctrl_hit(req);

  // Unimplemented bits are dropped before they can reach storage.
  assign wr_fields = f_fields(f_implemented(req.wdata));

  // Every bit holds unless a write to the control register lands this cycle.
  always_comb begin
    dac_off_nxt = dac_off_r;
    adc_compute_off_nxt = adc_compute_off_r;
    comparator_two_off_nxt = comparator_two_off_r;
    comparator_one_off_nxt = comparator_one_off_r;
    zero_cross_sw_nxt = zero_cross_sw_r;
    if (wr_ctrl) begin
      dac_off_nxt = wr_fields.dac_off;
      adc_compute_off_nxt = wr_fields.adc_compute_off;
      comparator_two_off_nxt = wr_fields.comparator_two_off;
      comparator_one_off_nxt = wr_fields.comparator_one_off;
      zero_cross_sw_nxt = wr_fields.zero_cross_off;
    end
  end

  // DAC disable bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_off_r <= PMDB2_RESET[PMDB2_BIT_DAC];
    end else begin
      dac_off_r <= dac_off_nxt;
    end
  end

  // Disable bit of the converter with computation.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_compute_off_r <= PMDB2_RESET[PMDB2_BIT_ADC];
    end else begin
      adc_compute_off_r <= adc_compute_off_nxt;
    end
  end

  // Comparator two disable bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comparator_two_off_r <= PMDB2_RESET[PMDB2_BIT_COMPARATOR_TWO];
    end else begin
      comparator_two_off_r <= comparator_two_off_nxt;
    end
  end

  // Comparator one disable bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comparator_one_off_r <= PMDB2_RESET[PMDB2_BIT_COMPARATOR_ONE];
    end else begin
      comparator_one_off_r <= comparator_one_off_nxt;
    end
  end

  // Software copy of the zero-cross disable bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zero_cross_sw_r <= PMDB2_RESET[PMDB2_BIT_ZCD];
    end else begin
      zero_cross_sw_r <= zero_cross_sw_nxt;
    end
  end

  // Collects the stored bits for the read path.
  always_comb begin
    stored_bits.dac_off = dac_off_r;
    stored_bits.adc_compute_off = adc_compute_off_r;
    stored_bits.comparator_two_off = comparator_two_off_r;
    stored_bits.comparator_one_off = comparator_one_off_r;
    stored_bits.zero_cross_off = zero_cross_sw_r;
  end

  assign image = f_image(stored_bits);

  // Read data stand only in the cycle after the read strobe and are zero otherwise,
  // so a stale byte can never be taken for a fresh one.
  always_comb begin
    rdata_nxt = '0;
    if (rd_ctrl) begin
      rdata_nxt = image;
    end
  end

  // Read data register; it clears itself in the cycle after the read data stand, unless another read strobe falls there.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Software owns the detector only when the configuration hands it over; the forced
  // level acts even while the register is held in reset.
  always_comb begin
    zero_cross_eff = zero_cross_config_forced_off;
    if (zero_cross_config_sw_ctrl) begin
      zero_cross_eff = zero_cross_sw_r;
    end
  end

  // The first four outputs come straight from flops, so the modules never see a glitch.
  always_comb begin
    module_off.dac_off = dac_off_r;
    module_off.adc_compute_off = adc_compute_off_r;
    module_off.comparator_two_off = comparator_two_off_r;
    module_off.comparator_one_off = comparator_one_off_r;
    module_off.zero_cross_off = zero_cross_eff;
  end
endmodule
`default_nettype wire

// File: test/pmdb2_chk.sv
/* Checker on the pmdb2_top ports. Assumes it is bound onto that module. */
`timescale 1ns/10ps
`default_nettype none
module pmdb2_chk
  import pmdb2_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [PMDB2_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic zero_cross_config_sw_ctrl,
  input wire logic zero_cross_config_forced_off,
  input wire pmdb2_off_t module_off
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic wr_hit;
  logic rd_hit;
  logic rd_miss;
  logic sw;
  logic [3:0] held_bits;
  assign wr_hit = reg_wr && (reg_addr == PMDB2_OFF_CTRL);
  assign rd_hit = reg_rd && (reg_addr == PMDB2_OFF_CTRL);
  assign rd_miss = reg_rd && (reg_addr != PMDB2_OFF_CTRL);
  assign sw = zero_cross_config_sw_ctrl;
  assign held_bits = {module_off.dac_off, module_off.adc_compute_off,
    module_off.comparator_two_off, module_off.comparator_one_off};

  sequence s_ctrl_write;
    wr_hit;
  endsequence

  sequence s_write_then_read;
    s_ctrl_write ##1 rd_hit;
  endsequence

  a_dac_off: assert property (s_ctrl_write |=>
    module_off.dac_off == $past(reg_wdata[PMDB2_BIT_DAC])) else $error("dac bit not taken");
  a_adc_off: assert property (s_ctrl_write |=>
    module_off.adc_compute_off == $past(reg_wdata[PMDB2_BIT_ADC])) else $error("adc bit not taken");
  a_cmp_two: assert property (s_ctrl_write |=>
    module_off.comparator_two_off == $past(reg_wdata[PMDB2_BIT_COMPARATOR_TWO])) else $error("comparator_two bit");
  a_cmp_one: assert property (s_ctrl_write |=>
    module_off.comparator_one_off == $past(reg_wdata[PMDB2_BIT_COMPARATOR_ONE])) else $error("comparator_one bit");
  a_zcd_soft: assert property (s_ctrl_write ##1 sw |->
    module_off.zero_cross_off == $past(reg_wdata[PMDB2_BIT_ZCD])) else $error("zc bit not taken");
  a_zcd_cfg: assert property (!sw |->
    module_off.zero_cross_off == zero_cross_config_forced_off) else $error("zc config ignored");
  a_read_back: assert property (s_write_then_read |=>
    reg_rdata == ($past(reg_wdata, 2) & PMDB2_IMPL_MASK)) else $error("read back wrong");
  a_read_zero: assert property (rd_miss |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_unimpl_zero: assert property ((reg_rdata & ~PMDB2_IMPL_MASK) == 8'h00)
    else $error("unimplemented bit read as one");
  a_bits_hold: assert property (!wr_hit |=> $stable(held_bits))
    else $error("disable bit changed without a write");
endmodule
bind pmdb2_top pmdb2_chk i_chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .zero_cross_config_sw_ctrl(zero_cross_config_sw_ctrl),
  .zero_cross_config_forced_off(zero_cross_config_forced_off),
  .module_off(module_off)
);
`default_nettype wire

// File: test/pmdb2_top_bench.sv
/* Bench for pmdb2_top. Assumes the bound checker beside it. */
`timescale 1ns/10ps
`default_nettype none
module pmdb2_top_bench;
  import pmdb2_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic zero_cross_config_sw_ctrl = 1'b1, zero_cross_config_forced_off = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  pmdb2_off_t module_off;
  int n_fail = 0, cmp_count = 0;
  pmdb2_top i_pmdb2_top (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .zero_cross_config_sw_ctrl(zero_cross_config_sw_ctrl),
    .zero_cross_config_forced_off(zero_cross_config_forced_off),
    .module_off(module_off)
  );
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) n_fail++;
    if (s !== e) $display("MISMATCH %0t %h %h", $time, s, e);
  endtask
  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic t_bits;
    logic [7:0] v [6] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h40, 8'hFF};
    foreach (v[i]) begin
      acc(4'h0, v[i], 1'b1);
      chk({3'h0, module_off}, {3'h0, v[i][6:5], v[i][2:0]});
      acc(4'h0, 8'h00, 1'b0);
      chk(reg_rdata, v[i] & 8'h67);
    end
    $display("bits done");
  endtask
  task automatic t_map;
    acc(4'h1, 8'h00, 1'b1);
    acc(4'h1, 8'h00, 1'b0);
    chk(reg_rdata, 8'h00);
    acc(4'h0, 8'h00, 1'b0);
    chk(reg_rdata, 8'h67);
    $display("map done");
  endtask
  task automatic t_cfg;
    @(posedge clk_sys);
    zero_cross_config_sw_ctrl <= 1'b0;
    #1;
    chk({7'h0, module_off.zero_cross_off}, 8'h00);
    @(posedge clk_sys);
    zero_cross_config_forced_off <= 1'b1;
    #1;
    chk({7'h0, module_off.zero_cross_off}, 8'h01);
    @(posedge clk_sys);
    zero_cross_config_sw_ctrl <= 1'b1;
    $display("cfg done");
  endtask
  task automatic t_b2b;
    @(posedge clk_sys);
    reg_addr <= PMDB2_OFF_CTRL;
    reg_wdata <= 8'hB5;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h25);
    chk({3'h0, module_off}, 8'h0D);
    $display("b2b done");
  endtask
  task automatic t_reset;
    @(posedge clk_sys);
    rstn <= 1'b0;
    #1;
    chk({3'h0, module_off}, 8'h00);
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(4'h0, 8'h00, 1'b0);
    chk(reg_rdata, 8'h00);
    $display("reset done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_bits;
    t_map;
    t_cfg;
    t_b2b;
    t_reset;
    close_out;
  end
  initial begin
    #100000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
